// >>> rtl/ssq_pkg.sv
package ssq_pkg;

  // ----------------------------------------------------------------
  // clocking and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS       = 20;
  localparam int SLOW_DIV_DEF        = 1525;
  localparam int FAST_DIV_DEF        = 5;
  localparam int FAST_OSC_STARTUP_NS = 2000;
  localparam int FAST_OSC_STARTUP_CYC =
    (FAST_OSC_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CFG    = 8'h00;
  localparam logic [7:0] OFS_TIMING = 8'h04;
  localparam logic [7:0] OFS_CMD    = 8'h08;
  localparam logic [7:0] OFS_CHANNEL_ENABLE_BITS   = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [1:0] CHCFG_PAGE = 2'h1;

  // cfg fields
  localparam int TRIG_LSB  = 0;
  localparam int EVCON_BIT = 2;
  localparam int ONDEM_BIT = 3;
  // timing fields
  localparam int LFP_LSB   = 0;
  localparam int HFP_LSB   = 4;
  localparam int PCP_LSB   = 8;
  localparam int PERIOD_TOP_VALUE_LSB = 12;
  localparam int STDLY_LSB = 20;
  // per-channel config fields
  localparam int EXDUR_LSB  = 0;
  localparam int MDLY_LSB   = 8;
  localparam int SDLY_LSB   = 16;
  localparam int EXCITE_CLOCK_SELECT_BIT  = 24;
  localparam int SCLK_BIT   = 25;
  localparam int EXCITE_PIN_MODE_LSB = 26;
  localparam int ALTERNATE_EXCITE_ENABLE_BIT  = 28;
  localparam int IDLE_LSB   = 29;
  localparam int START_BIT  = 0;

  localparam logic [3:0]  CFG_RST   = 4'h0;
  localparam logic [27:0] TIM_RST   = 28'h000_0000;
  localparam logic [15:0] CHANNEL_ENABLE_BITS_RST  = 16'h0000;
  localparam logic [30:0] CHCFG_RST = 31'h0000_0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TRIG_PERIODIC = 2'h0,
    TRIG_SINGLE   = 2'h1,
    TRIG_EVENT    = 2'h2
  } ssq_trig_t;

  typedef enum logic [1:0] {
    PIN_DISABLED = 2'h0,
    PIN_HIGH     = 2'h1,
    PIN_LOW      = 2'h2,
    PIN_DAC      = 2'h3
  } ssq_pin_t;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_SDLY   = 5'h02,
    ST_CHIDLE = 5'h04,
    ST_EXCITE = 5'h08,
    ST_MEAS   = 5'h10
  } ssq_state_t;

endpackage : ssq_pkg

// >>> rtl/ssq_tick_div.sv
`timescale 1ns/1ns
// passes every divisor-th input enable; a divisor of zero acts as one
module ssq_tick_div #(
  parameter int W = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         clr,
  input  wire logic         inTick,
  input  wire logic [W-1:0] divisor,
  output logic              outTick
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] last;

  assign last    = (divisor == '0) ? '0 : divisor - W'(1);
  assign outTick = inTick && (cnt_reg >= last);

  always_ff @(posedge sys_clk) begin
    if (!rst_n || clr) begin
      cnt_reg <= '0;
    end else if (outTick) begin
      cnt_reg <= '0;
    end else if (inTick) begin
      cnt_reg <= cnt_reg + W'(1);
    end
  end

endmodule : ssq_tick_div

// >>> rtl/ssq_sensor_scan_sequencer.sv
`timescale 1ns/1ns
// Function
// - slow and fast sense ticks time phases; registers on the bus clock.
// - every enabled channel is measured once per scan.
// - periodic mode: prescaled period counter starts a scan at its top value.
// - scan rate is slow clock / ((1 + top) * 2^exponent).
// - single-trigger mode: one scan per write of the start bit.
// - event mode: routed event starts a scan when consumer input configured.
// - start while idle begins at once, period schedule untouched.
// - period overflow during a scan runs that scan right after.
// - slow and fast timing prescalers with their own factors.
// - each channel walks idle, excite and measure phases.
// - excite/measure count excite clock; sample delay counts sample clock.
// - excite pulse lasts excite_duration selected-clock cycles.
// - comparator ignored for measure_ignore_delay excite-clock cycles.
// - sample taken after sample_delay sample-clock cycles.
// - programmable pre-measure delay before measuring begins.
// - on-demand fast oscillator requested at excite; timing waits start-up.
// - excitation on the active channel's own output unless alternate.
// - excite pin mode: disabled, high, low or DAC output.
// - DAC excitation only through three dedicated switches for channels 0-2.
// - channels 0-2 may hold DAC output connected while idle.
// - alternate excite uses output (x+8) mod 16.
// - enable bit x enables channel x; ascending order from lowest.
// - active pin disabled as analog input throughout measure.
// - own pin tri-stated after excite; alternate pin returns straight to idle.
module ssq_sensor_scan_sequencer #(
  parameter int SLOW_DIV = ssq_pkg::SLOW_DIV_DEF,
  parameter int FAST_DIV = ssq_pkg::FAST_DIV_DEF
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        routedEvent,
  output logic             fastOscRequest,
  output logic      [15:0] chOut,
  output logic      [15:0] chOeN,
  output logic      [2:0]  dacSwitch,
  output logic      [3:0]  activeChannel,
  output logic             scanBusy,
  output logic             compareEnable,
  output logic             sampleStrobe
);

  // ----------------------------------------------------------------
  // avalon slave
  // ----------------------------------------------------------------
  logic        ack_reg;
  logic        wrTake;
  logic        isCh;
  logic [31:0] rdMux;
  logic [31:0] wrMerged;
  logic [31:0] readdata_reg;
  logic [3:0]  cfg_reg;
  logic [27:0] tim_reg;
  logic [15:0] channel_enable_bits_reg;
  logic [30:0] chCfg_reg [16];
  logic        startCmd;
  ssq_pkg::ssq_state_t state_reg;
  logic [3:0]  activeCh_reg;

  // one wait cycle per access gives the read mux a full cycle
  assign waitrequest = (read || write) && !ack_reg;
  assign wrTake      = write && ack_reg;
  assign isCh        = (address[7:6] == ssq_pkg::CHCFG_PAGE) && (address[1:0] == 2'h0);
  assign startCmd    = wrTake && (address == ssq_pkg::OFS_CMD) && byteenable[0]
                       && writedata[ssq_pkg::START_BIT];
  assign readdata    = readdata_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read || write) && !ack_reg;
    end
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    if (isCh) begin
      rdMux = {1'b0, chCfg_reg[address[5:2]]};
    end else begin
      unique case (address)
        ssq_pkg::OFS_CFG:    rdMux = {28'h000_0000, cfg_reg};
        ssq_pkg::OFS_TIMING: rdMux = {4'h0, tim_reg};
        ssq_pkg::OFS_CHANNEL_ENABLE_BITS:   rdMux = {16'h0000, channel_enable_bits_reg};
        ssq_pkg::OFS_STATUS: rdMux = {22'h00_0000, state_reg, activeCh_reg, scanBusy};
        default:             rdMux = 32'h0000_0000;
      endcase
    end
    wrMerged = rdMux;
    for (int b = 0; b < 4; b++) begin
      if (byteenable[b]) begin
        wrMerged[8*b +: 8] = writedata[8*b +: 8];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      readdata_reg <= 32'h0000_0000;
    end else if (read && !ack_reg) begin
      readdata_reg <= rdMux;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_reg  <= ssq_pkg::CFG_RST;
      tim_reg  <= ssq_pkg::TIM_RST;
      channel_enable_bits_reg <= ssq_pkg::CHANNEL_ENABLE_BITS_RST;
      for (int i = 0; i < 16; i++) begin
        chCfg_reg[i] <= ssq_pkg::CHCFG_RST;
      end
    end else if (wrTake) begin
      if (isCh) begin
        chCfg_reg[address[5:2]] <= wrMerged[30:0];
      end else if (address == ssq_pkg::OFS_CFG) begin
        cfg_reg <= wrMerged[3:0];
      end else if (address == ssq_pkg::OFS_TIMING) begin
        tim_reg <= wrMerged[27:0];
      end else if (address == ssq_pkg::OFS_CHANNEL_ENABLE_BITS) begin
        channel_enable_bits_reg <= wrMerged[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // clock enables and prescalers
  // ----------------------------------------------------------------
  logic        slowTick;
  logic        fastBase;
  logic        slowPre;
  logic        fastPre;
  logic        periodTick;
  logic        oscReady;
  logic        start_when_needed;
  logic [15:0] oscCnt_reg;
  logic [1:0]  trigMode;
  logic [7:0]  period_top_value;
  logic [7:0]  pre_measure_delay;
  logic [7:0]  periodCnt_reg;

  assign start_when_needed = cfg_reg[ssq_pkg::ONDEM_BIT];
  assign trigMode = cfg_reg[ssq_pkg::TRIG_LSB +: 2];
  assign period_top_value    = tim_reg[ssq_pkg::PERIOD_TOP_VALUE_LSB +: 8];
  assign pre_measure_delay = tim_reg[ssq_pkg::STDLY_LSB +: 8];
  assign oscReady = (oscCnt_reg == 16'(ssq_pkg::FAST_OSC_STARTUP_CYC));

  ssq_tick_div u_slowBase (.sys_clk(sys_clk), .rst_n(rst_n), .clr(1'b0), .inTick(1'b1),
    .divisor(16'(SLOW_DIV)), .outTick(slowTick));
  ssq_tick_div u_fastBase (.sys_clk(sys_clk), .rst_n(rst_n), .clr(1'b0), .inTick(1'b1),
    .divisor(16'(FAST_DIV)), .outTick(fastBase));
  ssq_tick_div u_slowPre (.sys_clk(sys_clk), .rst_n(rst_n), .clr(1'b0), .inTick(slowTick),
    .divisor(16'h0001 << tim_reg[ssq_pkg::LFP_LSB +: 4]), .outTick(slowPre));
  ssq_tick_div u_fastPre (.sys_clk(sys_clk), .rst_n(rst_n), .clr(!oscReady),
    .inTick(fastBase && oscReady),
    .divisor(16'h0001 << tim_reg[ssq_pkg::HFP_LSB +: 4]), .outTick(fastPre));
  ssq_tick_div u_period (.sys_clk(sys_clk), .rst_n(rst_n), .clr(1'b0), .inTick(slowTick),
    .divisor(16'h0001 << tim_reg[ssq_pkg::PCP_LSB +: 4]), .outTick(periodTick));

  // the oscillator counts its start-up only while it is requested
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !fastOscRequest) begin
      oscCnt_reg <= 16'h0000;
    end else if (!oscReady) begin
      oscCnt_reg <= oscCnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // scan triggers
  // ----------------------------------------------------------------
  logic periodWrap;
  logic periodPend_reg;
  logic cmdPend_reg;
  logic eventPend_reg;
  logic anyStart;
  logic stIdle;

  assign stIdle     = (state_reg == ssq_pkg::ST_IDLE);
  assign periodWrap = periodTick && (trigMode == ssq_pkg::TRIG_PERIODIC)
                      && (periodCnt_reg == period_top_value);
  assign anyStart   = periodPend_reg || cmdPend_reg || eventPend_reg;

  // free-running schedule; interleaved scans never touch it
  always_ff @(posedge sys_clk) begin
    if (!rst_n || trigMode != ssq_pkg::TRIG_PERIODIC) begin
      periodCnt_reg <= 8'h00;
    end else if (periodWrap) begin
      periodCnt_reg <= 8'h00;
    end else if (periodTick) begin
      periodCnt_reg <= periodCnt_reg + 8'h01;
    end
  end

  // a new trigger wins over the clear of the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      periodPend_reg <= 1'b0;
      cmdPend_reg    <= 1'b0;
      eventPend_reg  <= 1'b0;
    end else begin
      periodPend_reg <= periodWrap || (periodPend_reg && !stIdle);
      cmdPend_reg    <= startCmd || (cmdPend_reg && !stIdle);
      eventPend_reg  <= (routedEvent && trigMode == ssq_pkg::TRIG_EVENT
                         && cfg_reg[ssq_pkg::EVCON_BIT])
                        || (eventPend_reg && !stIdle);
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic [15:0] remEn_reg;
  logic [15:0] remAfter;
  logic [30:0] curCfg_reg;
  logic [7:0]  phCnt_reg;
  logic [7:0]  mCnt_reg;
  logic [7:0]  sCnt_reg;
  logic [4:0]  pickFirst;
  logic [4:0]  pickNext;
  logic        exTick;
  logic        smTick;
  logic        sdlyDone;
  logic        chIdleDone;
  logic        exDone;
  logic        smDone;
  logic [7:0]  exDur;
  logic [7:0]  mDly;
  logic [7:0]  sDly;
  logic [3:0]  exPin;

  function automatic logic [4:0] lowestSet(input logic [15:0] m);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : lowestSet

  assign exDur      = curCfg_reg[ssq_pkg::EXDUR_LSB +: 8];
  assign mDly       = curCfg_reg[ssq_pkg::MDLY_LSB +: 8];
  assign sDly       = curCfg_reg[ssq_pkg::SDLY_LSB +: 8];
  assign exTick     = curCfg_reg[ssq_pkg::EXCITE_CLOCK_SELECT_BIT] ? fastPre : slowPre;
  assign smTick     = curCfg_reg[ssq_pkg::SCLK_BIT] ? fastPre : slowPre;
  assign remAfter   = remEn_reg & ~(16'h0001 << activeCh_reg);
  assign pickFirst  = lowestSet(remEn_reg);
  assign pickNext   = lowestSet(remAfter);
  assign sdlyDone   = (pre_measure_delay == 8'h00) || (slowPre && phCnt_reg + 8'h01 == pre_measure_delay);
  assign chIdleDone = slowPre;
  assign exDone     = (exDur == 8'h00) || (exTick && phCnt_reg + 8'h01 == exDur);
  assign smDone     = (sDly == 8'h00) || (smTick && sCnt_reg + 8'h01 == sDly);
  assign exPin      = curCfg_reg[ssq_pkg::ALTERNATE_EXCITE_ENABLE_BIT] ? 4'(activeCh_reg + 4'h8)
                                                     : activeCh_reg;
  assign scanBusy      = !stIdle;
  assign activeChannel = activeCh_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg    <= ssq_pkg::ST_IDLE;
      remEn_reg    <= 16'h0000;
      activeCh_reg <= 4'h0;
      curCfg_reg   <= ssq_pkg::CHCFG_RST;
      phCnt_reg    <= 8'h00;
    end else begin
      unique case (state_reg)
        ssq_pkg::ST_IDLE: begin
          phCnt_reg <= 8'h00;
          if (anyStart) begin
            remEn_reg <= channel_enable_bits_reg;
            state_reg <= ssq_pkg::ST_SDLY;
          end
        end
        ssq_pkg::ST_SDLY: begin
          if (!sdlyDone) begin
            phCnt_reg <= slowPre ? phCnt_reg + 8'h01 : phCnt_reg;
          end else if (!pickFirst[4]) begin
            state_reg <= ssq_pkg::ST_IDLE;
          end else begin
            activeCh_reg <= pickFirst[3:0];
            curCfg_reg   <= chCfg_reg[pickFirst[3:0]];
            phCnt_reg    <= 8'h00;
            state_reg    <= ssq_pkg::ST_CHIDLE;
          end
        end
        ssq_pkg::ST_CHIDLE: begin
          if (chIdleDone) begin
            state_reg <= ssq_pkg::ST_EXCITE;
          end
        end
        ssq_pkg::ST_EXCITE: begin
          if (exDone) begin
            state_reg <= ssq_pkg::ST_MEAS;
          end else if (exTick) begin
            phCnt_reg <= phCnt_reg + 8'h01;
          end
        end
        ssq_pkg::ST_MEAS: begin
          if (smDone) begin
            remEn_reg <= remAfter;
            phCnt_reg <= 8'h00;
            if (pickNext[4]) begin
              activeCh_reg <= pickNext[3:0];
              curCfg_reg   <= chCfg_reg[pickNext[3:0]];
              state_reg    <= ssq_pkg::ST_CHIDLE;
            end else begin
              state_reg <= ssq_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // measure window counters
  always_ff @(posedge sys_clk) begin
    if (!rst_n || state_reg != ssq_pkg::ST_MEAS) begin
      mCnt_reg <= 8'h00;
      sCnt_reg <= 8'h00;
    end else begin
      if (exTick && mCnt_reg != mDly) begin
        mCnt_reg <= mCnt_reg + 8'h01;
      end
      if (smTick) begin
        sCnt_reg <= sCnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      compareEnable  <= 1'b0;
      sampleStrobe   <= 1'b0;
      fastOscRequest <= 1'b0;
    end else begin
      compareEnable  <= (state_reg == ssq_pkg::ST_MEAS) && (mCnt_reg >= mDly);
      sampleStrobe   <= (state_reg == ssq_pkg::ST_MEAS) && smDone;
      // on demand the oscillator is off in idle and pre-excite phases
      fastOscRequest <= !start_when_needed || (state_reg == ssq_pkg::ST_EXCITE)
                        || (state_reg == ssq_pkg::ST_MEAS);
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  logic [1:0]  pinMode [16];
  logic [15:0] chOut_next;
  logic [15:0] chOeN_next;
  logic [2:0]  dac_next;

  always_comb begin
    for (int p = 0; p < 16; p++) begin
      pinMode[p] = chCfg_reg[p][ssq_pkg::IDLE_LSB +: 2];
      if (state_reg == ssq_pkg::ST_EXCITE && 4'(p) == exPin) begin
        pinMode[p] = curCfg_reg[ssq_pkg::EXCITE_PIN_MODE_LSB +: 2];
      end
      // own pin passes through the disabled state; an alternate pin does not
      if (state_reg == ssq_pkg::ST_MEAS && 4'(p) == activeCh_reg) begin
        pinMode[p] = ssq_pkg::PIN_DISABLED;
      end
      chOut_next[p] = (pinMode[p] == ssq_pkg::PIN_HIGH);
      chOeN_next[p] = !((pinMode[p] == ssq_pkg::PIN_HIGH) || (pinMode[p] == ssq_pkg::PIN_LOW));
    end
    for (int d = 0; d < 3; d++) begin
      dac_next[d] = (pinMode[d] == ssq_pkg::PIN_DAC);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      chOut     <= 16'h0000;
      chOeN     <= 16'hFFFF;
      dacSwitch <= 3'h0;
    end else begin
      chOut     <= chOut_next;
      chOeN     <= chOeN_next;
      dacSwitch <= dac_next;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence sExciteEnd;
    state_reg == ssq_pkg::ST_EXCITE && exDone;
  endsequence

  sequence sLastSample;
    state_reg == ssq_pkg::ST_MEAS && smDone && !pickNext[4];
  endsequence

  a_period_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    periodWrap |=> periodCnt_reg == 8'h00 && periodPend_reg)
    else $error("period wrap did not restart counter or flag a scan");
  a_idle_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stIdle && cmdPend_reg && !periodTick
    |=> state_reg == ssq_pkg::ST_SDLY && periodCnt_reg == $past(periodCnt_reg))
    else $error("start while idle was delayed or moved the schedule");
  a_overflow_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
    periodPend_reg && !stIdle |=> periodPend_reg)
    else $error("period overflow lost during a scan");
  a_excite_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == ssq_pkg::ST_EXCITE && !exTick && exDur != 8'h00
    |=> state_reg == ssq_pkg::ST_EXCITE)
    else $error("excite ended without an excite clock tick");
  a_measure_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sExciteEnd |=> state_reg == ssq_pkg::ST_MEAS && mCnt_reg == 8'h00 && sCnt_reg == 8'h00)
    else $error("measure phase did not follow excite");
  a_ignore_cmp: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == ssq_pkg::ST_MEAS && mCnt_reg < mDly |=> !compareEnable)
    else $error("comparator enabled inside ignore window");
  a_sample_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sampleStrobe |-> $past(state_reg) == ssq_pkg::ST_MEAS
    && (state_reg == ssq_pkg::ST_CHIDLE || state_reg == ssq_pkg::ST_IDLE))
    else $error("sample strobe outside end of measure");
  a_meas_pin_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == ssq_pkg::ST_MEAS |=> chOeN[$past(activeCh_reg)])
    else $error("active pin driven during measure");
  a_osc_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !oscReady |-> !fastPre)
    else $error("fast timing ran before oscillator start-up");
  a_osc_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    start_when_needed && stIdle |=> !fastOscRequest)
    else $error("fast oscillator requested while idle in on-demand mode");
  a_channel_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == ssq_pkg::ST_CHIDLE && $past(state_reg) == ssq_pkg::ST_MEAS
    |-> activeCh_reg > $past(activeCh_reg))
    else $error("channels not taken in ascending order");
  a_scan_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sLastSample |=> stIdle && !scanBusy)
    else $error("sequencer not idle after last channel");

endmodule : ssq_sensor_scan_sequencer

// >>> verification/ssq_sensor_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// sensor side: notes which pins were driven
// ----------------------------------------
module ssq_sensor_model (
  input  wire logic        sys_clk,
  input  wire logic        clr,
  input  wire logic [15:0] chOut,
  input  wire logic [15:0] chOeN,
  output logic      [15:0] drivenSeen,
  output logic      [15:0] highSeen
);
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      drivenSeen <= 16'h0000;
      highSeen   <= 16'h0000;
    end else begin
      drivenSeen <= drivenSeen | ~chOeN;
      highSeen   <= highSeen | (~chOeN & chOut);
    end
  end
endmodule : ssq_sensor_model

// >>> verification/tb_sensor_scan_sequencer.sv
`timescale 1ns/1ns
module tb_sensor_scan_sequencer;
  logic sys_clk = 0, rst_n = 0, read = 0, write = 0, routedEvent = 0, clr = 1;
  logic [7:0]  address = 8'h00;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] writedata = 32'h0000_0000, rdata;
  logic [31:0] readdata;
  logic        waitrequest, fastOscRequest, scanBusy, compareEnable, sampleStrobe;
  logic [15:0] chOut, chOeN, drivenSeen, highSeen;
  logic [2:0]  dacSwitch;
  logic [3:0]  activeChannel;
  int          badCount = 0, totalChecks = 0;
  always #10 sys_clk = ~sys_clk;
  ssq_sensor_scan_sequencer #(.SLOW_DIV(4), .FAST_DIV(2)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .routedEvent(routedEvent), .fastOscRequest(fastOscRequest),
    .chOut(chOut), .chOeN(chOeN), .dacSwitch(dacSwitch), .activeChannel(activeChannel),
    .scanBusy(scanBusy), .compareEnable(compareEnable), .sampleStrobe(sampleStrobe));
  ssq_sensor_model model_u (.sys_clk(sys_clk), .clr(clr), .chOut(chOut), .chOeN(chOeN),
    .drivenSeen(drivenSeen), .highSeen(highSeen));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // waits for ack without a cycle budget; the watchdog cuts a hang
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    address <= a; writedata <= d; read <= !wr; write <= wr;
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    rdata = readdata;
    read <= 1'b0; write <= 1'b0;
  endtask : bus
  task scan(input logic [15:0] expMask, input logic [31:0] expN);
    int n, t; logic [15:0] seen; logic [3:0] last, prev; logic ce;
    n = 0; t = 0; seen = 16'h0000; last = 4'h0; prev = 4'h0; ce = 1'b0;
    while (scanBusy !== 1'b1 && t < 50) begin @(posedge sys_clk); t++; end
    while (scanBusy === 1'b1 && t < 3000) begin
      prev = activeChannel;
      @(posedge sys_clk); t++;
      ce = ce | (compareEnable === 1'b1);
      // the strobe lands on the same edge that the channel register moves on
      if (sampleStrobe === 1'b1) begin
        if (n > 0 && prev <= last) chk(prev, last + 4'h1);
        last = prev; seen[prev] = 1'b1; n++;
      end
    end
    chk(seen, expMask);
    chk(n, expN);
    chk(scanBusy, 1'b0);
    chk(ce, 1'b1);
  endtask : scan
  task rise(output int c);
    c = 0;
    while (scanBusy !== 1'b0 && c < 500) begin @(posedge sys_clk); c++; end
    while (scanBusy !== 1'b1 && c < 500) begin @(posedge sys_clk); c++; end
  endtask : rise
  task test_regs;
    bus(1'b0, ssq_pkg::OFS_CFG, 32'h0000_0000);
    chk(rdata, 32'h0000_0000);
    bus(1'b1, ssq_pkg::OFS_CFG, 32'h0000_0001);
    bus(1'b0, ssq_pkg::OFS_CFG, 32'h0000_0000);
    chk(rdata, 32'h0000_0001);
    bus(1'b0, 8'h20, 32'h0000_0000);
    chk(rdata, 32'h0000_0000);
    bus(1'b1, ssq_pkg::OFS_CHANNEL_ENABLE_BITS, 32'h0000_0005);
    bus(1'b0, ssq_pkg::OFS_CHANNEL_ENABLE_BITS, 32'h0000_0000);
    chk(rdata, 32'h0000_0005);
    bus(1'b0, ssq_pkg::OFS_STATUS, 32'h0000_0000);
    chk(rdata, 32'h0000_0020);
  endtask : test_regs
  task test_single;
    bus(1, ssq_pkg::OFS_TIMING, 32'h0010_0000);
    bus(1, 8'h40, 32'h0402_0102);
    bus(1, 8'h48, 32'h0402_0102);
    clr <= 1'b0;
    bus(1, ssq_pkg::OFS_CMD, 32'h0000_0001);
    scan(16'h0005, 2);
    chk(highSeen, 32'h0005);
    chk(drivenSeen, 32'h0005);
    repeat (100) @(posedge sys_clk);
    chk(scanBusy, 1'b0);
    clr <= 1'b1;
  endtask : test_single
  task test_alternate_excite_enable_event;
    bus(1, ssq_pkg::OFS_CHANNEL_ENABLE_BITS, 32'h0000_0002);
    bus(1, 8'h44, 32'h1402_0102);
    bus(1, ssq_pkg::OFS_CFG, 32'h0000_000E);
    clr <= 1'b0;
    @(posedge sys_clk) routedEvent <= 1'b1;
    @(posedge sys_clk) routedEvent <= 1'b0;
    scan(16'h0002, 1);
    chk(highSeen, 32'h0200);
    chk(drivenSeen, 32'h0200);
    repeat (2) @(posedge sys_clk);
    chk(fastOscRequest, 1'b0);
    bus(1, 8'h40, 32'h6000_0000);
    repeat (2) @(posedge sys_clk);
    chk(dacSwitch, 3'h1);
  endtask : test_alternate_excite_enable_event
  task test_periodic;
    int c;
    bus(1, ssq_pkg::OFS_TIMING, 32'h0010_F000);
    bus(1, ssq_pkg::OFS_CHANNEL_ENABLE_BITS, 32'h0000_0001);
    bus(1, ssq_pkg::OFS_CFG, 32'h0000_0000);
    rise(c);
    rise(c);
    // 4 cycles per slow tick, (1 + 15) ticks, prescale 2^0
    chk(c, 32'h0000_0040);
  endtask : test_periodic
  task give_verdict;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge sys_clk);
    badCount++;
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    test_regs;
    test_single;
    test_alternate_excite_enable_event;
    test_periodic;
    give_verdict;
  end
endmodule : tb_sensor_scan_sequencer
